// ---- hw/rfl_fifo.sv ----
// word fifo with a registered output stage
`timescale 1ns/10ps
`default_nettype none
module rfl_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         ce_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [CW-1:0]           cnt;
    logic                    ov;
    logic [W-1:0]            od;
  } rfl_fifo_state_s;
  rfl_fifo_state_s s, n;
  logic push, pop;

  assign in_ready_o  = (s.cnt != CW'(DEPTH));
  assign out_valid_o = s.ov;
  assign out_data_o  = s.od;

  always_comb
  begin
    n    = s;
    push = in_valid_i && in_ready_o;
    pop  = (s.cnt != '0) && (!s.ov || out_ready_i);
    if (s.ov && out_ready_i)
      n.ov = 1'b0;
    if (pop)
    begin
      n.od = s.mem[s.rp];
      n.ov = 1'b1;
      n.rp = AW'(s.rp + 1'b1);
    end
    if (push)
    begin
      n.mem[s.wp] = in_data_i;
      n.wp        = AW'(s.wp + 1'b1);
    end
    n.cnt = CW'(s.cnt + CW'(push) - CW'(pop));
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      s <= '0;
    else if (ce_i)
      s <= n;
  end
endmodule : rfl_fifo
`default_nettype wire

// ---- hw/rfl_map.svh ----
// register map, field positions and frame offsets of the frame reflector
`ifndef RFL_MAP_SVH
`define RFL_MAP_SVH
`define RFL_OFS_CTRL   6'h00
`define RFL_OFS_MACLO  6'h04
`define RFL_OFS_MACHI  6'h08
`define RFL_OFS_IP     6'h0C
`define RFL_OFS_VLAN0  6'h10
`define RFL_OFS_VLAN1  6'h14
`define RFL_OFS_VLAN2  6'h18
`define RFL_OFS_VLAN3  6'h1C
`define RFL_OFS_STAT   6'h20
`define RFL_OFS_STATE  6'h24
`define RFL_B_EN       0
`define RFL_B_SWMAC    1
`define RFL_B_SWIP     2
`define RFL_B_ARP      3
`define RFL_B_PING     4
`define RFL_B_VLAN     5
`define RFL_F_VCNT     11:8
`define RFL_CTRL_RST   12'h106
`define RFL_MEM_DEPTH  256
`define RFL_FIFO_DEPTH 8
`define RFL_VLAN_MAX   8
`define RFL_MAC_LEN    9'h006
`define RFL_ETYPE_OFS  9'h00C
`define RFL_ETYPE_LEN  9'h002
`define RFL_L3_BASE    9'h00E
`define RFL_TAG_LEN    9'h004
`define RFL_FCS_LEN    9'h004
`define RFL_MIN_LEN    9'h040
`define RFL_TPID_C     16'h8100
`define RFL_TPID_S     16'h88A8
`define RFL_ET_V4      16'h0800
`define RFL_ET_ARP     16'h0806
`define RFL_ET_V6      16'h86DD
`define RFL_V4_VIHL    8'h45
`define RFL_V4_PROTO   9'h009
`define RFL_PROTO_ICMP 8'h01
`define RFL_V4_SRC     9'h00C
`define RFL_V4_DST     9'h010
`define RFL_V4_END     9'h014
`define RFL_V4_ALEN    9'h004
`define RFL_V6_SRC     9'h008
`define RFL_V6_DST     9'h018
`define RFL_V6_END     9'h028
`define RFL_V6_ALEN    9'h010
`define RFL_ICMP_TYPE  9'h014
`define RFL_ICMP_CSUM  9'h016
`define RFL_ECHO_REQ   8'h08
`define RFL_ECHO_REP   8'h00
`define RFL_CSUM_ADJ   16'h0800
`define RFL_ARP_OP     9'h006
`define RFL_ARP_SHA    9'h008
`define RFL_ARP_SPA    9'h00E
`define RFL_ARP_THA    9'h012
`define RFL_ARP_TPA    9'h018
`define RFL_ARP_END    9'h01C
`define RFL_ARP_SWAP   9'h00A
`define RFL_OP_REQ     16'h0001
`define RFL_OP_REP     8'h02
`define RFL_CRC_INIT   32'hFFFFFFFF
`define RFL_CRC_POLY   32'hEDB88320
`endif

// ---- hw/rfl_pkg.sv ----
// types shared by the frame reflector modules
`default_nettype none
`include "rfl_map.svh"
package rfl_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RECV = 5'b00010,
    ST_DEC  = 5'b00100,
    ST_SEND = 5'b01000,
    ST_DROP = 5'b10000
  } rfl_st_e;
  typedef enum logic [2:0] {
    MD_REFL = 3'b001,
    MD_ARP  = 3'b010,
    MD_PING = 3'b100
  } rfl_mode_e;
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } rfl_byte_s;
  typedef logic [`RFL_MEM_DEPTH-1:0][7:0] rfl_mem_t;
  typedef struct packed {
    rfl_st_e                        st;
    rfl_mode_e                      mode;
    rfl_mem_t                       mem;
    logic [8:0]                     len;
    logic [8:0]                     idx;
    logic [31:0]                    crc;
    logic                           in_fr;
    logic [11:0]                    ctrl;
    logic [47:0]                    own_mac;
    logic [31:0]                    own_ip;
    logic [`RFL_VLAN_MAX-1:0][11:0] vid;
    logic [15:0]                    n_refl;
    logic [15:0]                    n_drop;
    logic                           waitreq;
    logic [31:0]                    rdata;
  } rfl_state_s;
endpackage : rfl_pkg
`default_nettype wire

// ---- hw/rfl_reflector.sv ----
// ethernet frame reflector: capture, classify, rewrite and send back
`timescale 1ns/10ps
`default_nettype none
`include "rfl_map.svh"
module rfl_reflector (
  input  wire logic                CLK_I,
  input  wire logic                RESETN_I,
  input  wire logic                CE_I,
  input  wire logic                FULL_DUPLEX_I,
  input  wire logic                RX_VALID_I,
  input  wire rfl_pkg::rfl_byte_s  RX_DATA_I,
  output logic                     TX_VALID_O,
  output rfl_pkg::rfl_byte_s       TX_DATA_O,
  input  wire logic                TX_READY_I,
  input  wire logic [5:0]          AVS_ADDRESS_I,
  input  wire logic                AVS_READ_I,
  input  wire logic                AVS_WRITE_I,
  input  wire logic [31:0]         AVS_WRITEDATA_I,
  input  wire logic [3:0]          AVS_BYTEENABLE_I,
  output logic [31:0]              AVS_READDATA_O,
  output logic                     AVS_WAITREQUEST_O
);
  import rfl_pkg::*;

  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int j = 0; j < 8; j++)
      r = (r >> 1) ^ ((r[0] ^ b[j]) ? `RFL_CRC_POLY : 32'h0);
    return r;
  endfunction : crc8

  function automatic logic [7:0] mb(input rfl_mem_t m, input logic [8:0] a);
    return m[a[7:0]];
  endfunction : mb

  function automatic logic [31:0] m32(input rfl_mem_t m, input logic [8:0] a);
    return {mb(m, a), mb(m, 9'(a + 1)), mb(m, 9'(a + 2)), mb(m, 9'(a + 3))};
  endfunction : m32

  function automatic rfl_state_s rst_val();
    rfl_state_s v;
    v         = '0;
    v.st      = ST_IDLE;
    v.mode    = MD_REFL;
    v.ctrl    = `RFL_CTRL_RST;
    v.crc     = `RFL_CRC_INIT;
    v.waitreq = 1'b1;
    return v;
  endfunction : rst_val

  localparam rfl_state_s RST_S = rst_val();

  rfl_state_s  s, n;
  rfl_byte_s   f_din;
  logic        f_rdy, snd, vlan_ok, is_v4, is_v6, mcast, arp_hit, ping_hit, ipsw, last_b;
  logic [3:0]  vcnt;
  logic [8:0]  l3, rel, body, tp;
  logic [15:0] etype, cs, adj;
  logic [16:0] s17;
  logic [7:0]  tx_b;
  logic [31:0] rw, wm, fcs;
  logic [2:0]  vj;

  // ----------------------------------------------------------------
  // frame classification
  // ----------------------------------------------------------------
  always_comb
  begin
    vcnt    = s.ctrl[`RFL_B_VLAN] ? s.ctrl[`RFL_F_VCNT] : 4'h0;
    l3      = 9'(`RFL_L3_BASE + `RFL_TAG_LEN * vcnt);
    vlan_ok = !(s.ctrl[`RFL_B_VLAN] && vcnt > 4'(`RFL_VLAN_MAX));
    tp      = `RFL_ETYPE_OFS;
    for (int k = 0; k < `RFL_VLAN_MAX; k++)
    begin
      tp = 9'(`RFL_ETYPE_OFS + `RFL_TAG_LEN * k);
      if (k < int'(vcnt))
        if (!(m32(s.mem, tp) == {`RFL_TPID_C, 4'h0, s.vid[k]}
            || m32(s.mem, tp) == {`RFL_TPID_S, 4'h0, s.vid[k]}))
          vlan_ok = 1'b0;
    end
    etype = {mb(s.mem, 9'(l3 - `RFL_ETYPE_LEN)), mb(s.mem, 9'(l3 - 1))};
    is_v4 = etype == `RFL_ET_V4 && mb(s.mem, l3) == `RFL_V4_VIHL;
    is_v6 = etype == `RFL_ET_V6;
    mcast = s.mem[0][0];
    arp_hit = s.ctrl[`RFL_B_ARP] && etype == `RFL_ET_ARP
      && {mb(s.mem, 9'(l3 + `RFL_ARP_OP)), mb(s.mem, 9'(l3 + `RFL_ARP_OP + 1))} == `RFL_OP_REQ
      && m32(s.mem, 9'(l3 + `RFL_ARP_TPA)) == s.own_ip;
    ping_hit = s.ctrl[`RFL_B_PING] && is_v4
      && mb(s.mem, 9'(l3 + `RFL_V4_PROTO)) == `RFL_PROTO_ICMP
      && mb(s.mem, 9'(l3 + `RFL_ICMP_TYPE)) == `RFL_ECHO_REQ
      && m32(s.mem, 9'(l3 + `RFL_V4_DST)) == s.own_ip;
    cs  = {mb(s.mem, 9'(l3 + `RFL_ICMP_CSUM)), mb(s.mem, 9'(l3 + `RFL_ICMP_CSUM + 1))};
    s17 = {1'b0, cs} + {1'b0, `RFL_CSUM_ADJ};
    adj = 16'(s17[15:0] + {15'h0, s17[16]});
  end

  // ----------------------------------------------------------------
  // outgoing byte rewrite
  // ----------------------------------------------------------------
  always_comb
  begin
    rel  = 9'(s.idx - l3);
    body = 9'(s.len - `RFL_FCS_LEN);
    ipsw = (s.mode == MD_REFL && s.ctrl[`RFL_B_SWIP]) || s.mode == MD_PING;
    tx_b = mb(s.mem, s.idx);
    if (s.mode != MD_REFL || s.ctrl[`RFL_B_SWMAC])
    begin
      if (s.idx < `RFL_MAC_LEN)
        tx_b = mb(s.mem, 9'(s.idx + `RFL_MAC_LEN));
      else if (s.idx < `RFL_ETYPE_OFS)
        tx_b = (s.mode == MD_REFL) ? mb(s.mem, 9'(s.idx - `RFL_MAC_LEN))
             : s.own_mac[8 * (11 - int'(s.idx)) +: 8];
    end
    if (ipsw && is_v4 && rel >= `RFL_V4_SRC && rel < `RFL_V4_END)
      tx_b = (rel < `RFL_V4_DST) ? mb(s.mem, 9'(s.idx + `RFL_V4_ALEN))
           : mb(s.mem, 9'(s.idx - `RFL_V4_ALEN));
    if (ipsw && s.mode == MD_REFL && is_v6 && rel >= `RFL_V6_SRC && rel < `RFL_V6_END)
      tx_b = (rel < `RFL_V6_DST) ? mb(s.mem, 9'(s.idx + `RFL_V6_ALEN))
           : mb(s.mem, 9'(s.idx - `RFL_V6_ALEN));
    if (s.mode == MD_PING)
    begin
      if (rel == `RFL_ICMP_TYPE)
        tx_b = `RFL_ECHO_REP;
      else if (rel == `RFL_ICMP_CSUM)
        tx_b = adj[15:8];
      else if (rel == 9'(`RFL_ICMP_CSUM + 1))
        tx_b = adj[7:0];
    end
    if (s.mode == MD_ARP)
    begin
      if (rel == `RFL_ARP_OP)
        tx_b = 8'h00;
      else if (rel == 9'(`RFL_ARP_OP + 1))
        tx_b = `RFL_OP_REP;
      else if (rel >= `RFL_ARP_SHA && rel < `RFL_ARP_SPA)
        tx_b = s.own_mac[8 * (13 - int'(rel)) +: 8];
      else if (rel >= `RFL_ARP_SPA && rel < `RFL_ARP_THA)
        tx_b = s.own_ip[8 * (17 - int'(rel)) +: 8];
      else if (rel >= `RFL_ARP_THA && rel < `RFL_ARP_END)
        tx_b = mb(s.mem, 9'(s.idx - `RFL_ARP_SWAP));
    end
    fcs    = ~s.crc;
    last_b = s.idx == 9'(s.len - 1);
    f_din.last = last_b;
    // fcs leaves least significant byte first
    f_din.data = (s.idx < body) ? tx_b : 8'(fcs >> {s.idx[1:0] - body[1:0], 3'b000});
  end

  rfl_fifo #(
    .W     (9),
    .DEPTH (`RFL_FIFO_DEPTH)
  ) u_txq (
    .clk_i       (CLK_I),
    .resetn_i    (RESETN_I),
    .ce_i        (CE_I),
    .in_valid_i  (s.st == ST_SEND),
    .in_data_i   (f_din),
    .in_ready_o  (f_rdy),
    .out_valid_o (TX_VALID_O),
    .out_data_o  (TX_DATA_O),
    .out_ready_i (TX_READY_I)
  );

  // ----------------------------------------------------------------
  // sequencing and register slave
  // ----------------------------------------------------------------
  always_comb
  begin
    n   = s;
    snd = s.st == ST_SEND && f_rdy;
    if (RX_VALID_I)
      n.in_fr = !RX_DATA_I.last;
    case (s.st)
      ST_IDLE:
        // frames that start while busy are never seen, so no partial captures
        if (RX_VALID_I && !s.in_fr)
        begin
          n.len = '0;
          if (s.ctrl[`RFL_B_EN] && FULL_DUPLEX_I)
          begin
            n.mem[0] = RX_DATA_I.data;
            n.len    = 9'h001;
            n.st     = RX_DATA_I.last ? ST_DEC : ST_RECV;
          end
          else
          begin
            n.n_drop = 16'(s.n_drop + 1'b1);
            n.st     = RX_DATA_I.last ? ST_IDLE : ST_DROP;
          end
        end
      ST_RECV:
        if (RX_VALID_I)
        begin
          if (s.len == 9'(`RFL_MEM_DEPTH))
          begin
            n.n_drop = 16'(s.n_drop + 1'b1);
            n.st     = RX_DATA_I.last ? ST_IDLE : ST_DROP;
          end
          else
          begin
            n.mem[s.len[7:0]] = RX_DATA_I.data;
            n.len = 9'(s.len + 1'b1);
            if (RX_DATA_I.last)
              n.st = ST_DEC;
          end
        end
      ST_DEC:
      begin
        n.idx  = '0;
        n.crc  = `RFL_CRC_INIT;
        n.mode = arp_hit ? MD_ARP : ping_hit ? MD_PING : MD_REFL;
        // only an arp answer may follow a group destination; echo replies may not
        if (s.len >= `RFL_MIN_LEN && vlan_ok && (arp_hit || (!mcast && (ping_hit
            || s.ctrl[`RFL_B_SWMAC] || s.ctrl[`RFL_B_SWIP]))))
          n.st = ST_SEND;
        else
        begin
          n.n_drop = 16'(s.n_drop + 1'b1);
          n.st     = ST_IDLE;
        end
      end
      ST_SEND:
        if (f_rdy)
        begin
          if (s.idx < body)
            n.crc = crc8(s.crc, tx_b);
          n.idx = 9'(s.idx + 1'b1);
          if (last_b)
          begin
            n.n_refl = 16'(s.n_refl + 1'b1);
            n.st     = ST_IDLE;
          end
        end
      ST_DROP:
        if (RX_VALID_I && RX_DATA_I.last)
          n.st = ST_IDLE;
      default:
        n.st = ST_IDLE;
    endcase

    vj = {AVS_ADDRESS_I[3:2], 1'b0};
    case (AVS_ADDRESS_I)
      `RFL_OFS_CTRL:  rw = {20'h0, s.ctrl};
      `RFL_OFS_MACLO: rw = s.own_mac[31:0];
      `RFL_OFS_MACHI: rw = {16'h0, s.own_mac[47:32]};
      `RFL_OFS_IP:    rw = s.own_ip;
      `RFL_OFS_VLAN0, `RFL_OFS_VLAN1, `RFL_OFS_VLAN2, `RFL_OFS_VLAN3:
        rw = {4'h0, s.vid[3'(vj + 3'h1)], 4'h0, s.vid[vj]};
      `RFL_OFS_STAT:  rw = {s.n_drop, s.n_refl};
      `RFL_OFS_STATE: rw = {24'h0, s.mode, s.st};
      default:        rw = 32'h0;
    endcase
    for (int b = 0; b < 4; b++)
      wm[8 * b +: 8] = AVS_BYTEENABLE_I[b] ? AVS_WRITEDATA_I[8 * b +: 8] : rw[8 * b +: 8];
    // one wait cycle, then the answer edge
    n.waitreq = !((AVS_READ_I || AVS_WRITE_I) && s.waitreq);
    if (AVS_READ_I && s.waitreq)
      n.rdata = rw;
    if (AVS_WRITE_I && !s.waitreq)
      case (AVS_ADDRESS_I)
        `RFL_OFS_CTRL:  n.ctrl = wm[11:0];
        `RFL_OFS_MACLO: n.own_mac[31:0] = wm;
        `RFL_OFS_MACHI: n.own_mac[47:32] = wm[15:0];
        `RFL_OFS_IP:    n.own_ip = wm;
        `RFL_OFS_VLAN0, `RFL_OFS_VLAN1, `RFL_OFS_VLAN2, `RFL_OFS_VLAN3:
        begin
          n.vid[vj] = wm[11:0];
          n.vid[3'(vj + 3'h1)] = wm[27:16];
        end
        default: n.rdata = s.rdata;
      endcase
  end

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      s <= RST_S;
    else if (CE_I)
      s <= n;
  end

  assign AVS_READDATA_O    = s.rdata;
  assign AVS_WAITREQUEST_O = s.waitreq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);

  a_hdx_block: assert property (
    (s.st == ST_IDLE && CE_I && RX_VALID_I && !FULL_DUPLEX_I) |=> s.st != ST_RECV)
    else $error("frame captured on half duplex link");
  a_mcast_drop: assert property (
    (s.st == ST_DEC && CE_I && mcast && !arp_hit) |=> s.st == ST_IDLE)
    else $error("multicast frame not dropped");
  a_mac_swap: assert property (
    (snd && s.mode == MD_REFL && s.ctrl[`RFL_B_SWMAC] && s.idx < `RFL_MAC_LEN)
    |-> tx_b == mb(s.mem, 9'(s.idx + `RFL_MAC_LEN)))
    else $error("destination mac not swapped");
  a_v6_swap: assert property (
    (snd && s.mode == MD_REFL && s.ctrl[`RFL_B_SWIP] && is_v6 && rel == `RFL_V6_SRC)
    |-> tx_b == mb(s.mem, 9'(s.idx + `RFL_V6_ALEN)))
    else $error("ipv6 source not swapped");
  a_arp_reply: assert property (
    (snd && s.mode == MD_ARP && rel == 9'(`RFL_ARP_OP + 1)) |-> tx_b == `RFL_OP_REP)
    else $error("arp opcode not reply");
  a_ping_reply: assert property (
    (snd && s.mode == MD_PING && rel == `RFL_ICMP_TYPE) |-> tx_b == `RFL_ECHO_REP)
    else $error("icmp type not echo reply");
  a_own_mac: assert property (
    (snd && s.mode != MD_REFL && s.idx == `RFL_MAC_LEN) |-> tx_b == s.own_mac[47:40])
    else $error("answer source mac wrong");
  a_vlan_drop: assert property (
    (s.st == ST_DEC && CE_I && !vlan_ok) |=> s.st == ST_IDLE ##1 s.st != ST_SEND)
    else $error("vlan mismatch reflected");
  a_payload_keep: assert property (
    (snd && s.mode == MD_REFL && s.idx >= 9'(l3 + `RFL_V6_END) && s.idx < body)
    |-> f_din.data == mb(s.mem, s.idx))
    else $error("payload byte altered");
  a_fcs_end: assert property (
    (snd && CE_I && last_b) |=> s.st == ST_IDLE && $past(s.idx) == 9'(s.len - 1))
    else $error("frame end not at fcs");

  c_reflect: cover property (snd && CE_I && last_b && s.mode == MD_REFL);
  c_arp: cover property (snd && CE_I && last_b && s.mode == MD_ARP);
  c_ping: cover property (snd && CE_I && last_b && s.mode == MD_PING);
  c_drop: cover property (s.st == ST_DEC && CE_I && mcast ##1 s.st == ST_IDLE);
endmodule : rfl_reflector
`default_nettype wire

// ---- testbench/rfl_partner.sv ----
// link partner model: feeds frames into the reflector and takes its output
`timescale 1ns/10ps
`default_nettype none
module rfl_partner (
  input  wire logic               clk_i,
  input  wire logic               rnd_i,
  input  wire logic               slow_i,
  output rfl_pkg::rfl_byte_s      rx_data_o,
  output logic                    rx_valid_o,
  input  wire logic               tx_valid_i,
  input  wire rfl_pkg::rfl_byte_s tx_data_i,
  output logic                    tx_ready_o,
  output logic                    got_v_o,
  output rfl_pkg::rfl_byte_s      got_b_o
);
  import rfl_pkg::*;
  // --------
  // sender
  // --------
  initial
  begin
    rx_valid_o = 1'b0;
    rx_data_o  = '0;
  end
  task automatic send(input logic [7:0] fr[$]);
    for (int i = 0; i < fr.size(); i++)
    begin
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_data_o  <= {i == fr.size() - 1, fr[i]};
    end
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    // idle line shows the inverse of the last byte, never a stale copy
    rx_data_o  <= ~rx_data_o;
  endtask : send
  // --------
  // receiver
  // --------
  // takes bytes at any spacing, so short interframe_gap is tolerated
  assign tx_ready_o = !slow_i || rnd_i;
  assign got_v_o    = tx_valid_i && tx_ready_o;
  assign got_b_o    = tx_data_i;
endmodule : rfl_partner
`default_nettype wire

// ---- testbench/rfl_reflector_tb.sv ----
// self-checking bench of the frame reflector
`timescale 1ns/10ps
`default_nettype none
`include "rfl_map.svh"
`define CHK(nm, ex, sn) begin checks++; if ((sn) !== (ex)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", nm, ex, sn); end end
module rfl_reflector_tb;
  import rfl_pkg::*;
  localparam logic [47:0]  OWN_MAC  = 48'h0211_2233_4455;
  localparam logic [31:0]  OWN_IP   = 32'hC0A8_0A01;
  localparam logic [47:0]  PEER_MAC = 48'h02AA_BBCC_DDEE;
  localparam logic [31:0]  PEER_IP  = 32'hC0A8_0A02;
  localparam logic [127:0] V6A      = 128'h20010DB8_0000_0000_0000_0000_0000_0001;
  localparam logic [127:0] V6B      = 128'h20010DB8_0000_0000_0000_0000_0000_0002;
  logic        clk      = 1'b0;
  logic        resetn   = 1'b0;
  logic        full_dup = 1'b1;
  logic [5:0]  adr      = 6'h00;
  logic        rd       = 1'b0;
  logic        wr       = 1'b0;
  logic [31:0] wdat     = 32'h0;
  logic        rnd      = 1'b0;
  logic        slow     = 1'b0;
  logic [31:0] rdat;
  logic        wreq;
  logic        rx_v;
  rfl_byte_s   rx_d;
  logic        tx_v;
  rfl_byte_s   tx_d;
  logic        tx_rdy;
  logic        got_v;
  rfl_byte_s   got_b;
  rfl_byte_s   xb;
  rfl_byte_s   exq[$];
  logic [7:0]  f[$];
  logic [7:0]  e[$];
  logic [31:0] x        = 32'h0A45;
  logic [31:0] dmy;
  logic        sm;
  logic        si;
  int          n_errors = 0;
  int          checks   = 0;
  int          n_drp    = 0;
  int          n_ref    = 0;
  int          cyc      = 0;
  rfl_reflector i_dut (
    .CLK_I             (clk),
    .RESETN_I          (resetn),
    .CE_I              (1'b1),
    .FULL_DUPLEX_I     (full_dup),
    .RX_VALID_I        (rx_v),
    .RX_DATA_I         (rx_d),
    .TX_VALID_O        (tx_v),
    .TX_DATA_O         (tx_d),
    .TX_READY_I        (tx_rdy),
    .AVS_ADDRESS_I     (adr),
    .AVS_READ_I        (rd),
    .AVS_WRITE_I       (wr),
    .AVS_WRITEDATA_I   (wdat),
    .AVS_BYTEENABLE_I  (4'hF),
    .AVS_READDATA_O    (rdat),
    .AVS_WAITREQUEST_O (wreq)
  );
  rfl_partner i_peer (
    .clk_i      (clk),
    .rnd_i      (rnd),
    .slow_i     (slow),
    .rx_data_o  (rx_d),
    .rx_valid_o (rx_v),
    .tx_valid_i (tx_v),
    .tx_data_i  (tx_d),
    .tx_ready_o (tx_rdy),
    .got_v_o    (got_v),
    .got_b_o    (got_b)
  );
  always #50 clk = ~clk;
  // --------
  // helpers
  // --------
  function automatic logic [31:0] xs();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  function automatic void add(logic [159:0] v, int n);
    for (int i = n - 1; i >= 0; i--) f.push_back(v[8*i +: 8]);
  endfunction : add
  function automatic void put(int at, logic [159:0] v, int n);
    for (int i = 0; i < n; i++) e[at+i] = v[8*(n-1-i) +: 8];
  endfunction : put
  function automatic void cp(int to, int fr, int n);
    for (int i = 0; i < n; i++) e[to+i] = f[fr+i];
  endfunction : cp
  function automatic logic [31:0] crc();
    logic [31:0] c;
    c = `RFL_CRC_INIT;
    foreach (e[i])
    begin
      c ^= {24'h0, e[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ `RFL_CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction : crc
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    adr  <= a;
    wr   <= w;
    rd   <= !w;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    if (n == 50) n_errors++;
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic setc(input logic [11:0] c);
    bus(1'b1, `RFL_OFS_CTRL, {20'h0, c}, dmy);
    sm = c[`RFL_B_SWMAC];
    si = c[`RFL_B_SWIP];
  endtask : setc
  // kinds: 0 ipv4, 1 ipv6, 2 arp request, 3 echo request
  task automatic build(input int k, input logic [47:0] dst, input int nv,
                       input logic [11:0] v1, input int len);
    f.delete();
    add({dst, PEER_MAC}, 12);
    for (int t = 0; t < nv; t++) add({16'h8100, 4'h0, t == 0 ? 12'h123 : v1}, 4);
    add(k == 1 ? `RFL_ET_V6 : k == 2 ? `RFL_ET_ARP : `RFL_ET_V4, 2);
    if (k == 0 || k == 3)
      add({8'h45, 56'h0, 8'h40, k == 3 ? 8'h01 : 8'h11, 16'h0, PEER_IP, OWN_IP}, 20);
    if (k == 3) add({16'h0800, 16'(xs()), 32'h0001_0001}, 8);
    if (k == 1) add({V6A, 32'h6000_0000}, 4);
    if (k == 1) add({32'h0000_1140, V6A}, 20);
    if (k == 1) add(V6B, 16);
    if (k == 2) add({64'h0001_0800_0604_0001, PEER_MAC, PEER_IP}, 18);
    if (k == 2) add({48'h0, OWN_IP}, 10);
    while (f.size() < len) add(xs(), 1);
  endtask : build
  task automatic expect_out(input int k, input int nv);
    int          l;
    logic [31:0] c;
    logic [16:0] s;
    l = 14 + 4 * nv;
    e = f;
    if ((sm && k < 2) || k > 1) cp(0, 6, 6);
    if ((sm && k < 2) || k > 1) cp(6, 0, 6);
    if (k > 1) put(6, OWN_MAC, 6);
    if ((si && k == 0) || k == 3) cp(l + 12, l + 16, 4);
    if ((si && k == 0) || k == 3) cp(l + 16, l + 12, 4);
    if (si && k == 1) cp(l + 8, l + 24, 16);
    if (si && k == 1) cp(l + 24, l + 8, 16);
    if (k == 2) put(l + 7, {8'h02, OWN_MAC, OWN_IP}, 11);
    if (k == 2) cp(l + 18, l + 8, 10);
    s = {f[l+22], f[l+23]} + 17'h00800;
    if (k == 3) put(l + 20, {8'h00, f[l+21], s[15:0] + s[16]}, 4);
    repeat (4) void'(e.pop_back());
    c = crc();
    for (int i = 0; i < 4; i++) e.push_back(c[8*i +: 8]);
    foreach (e[i]) exq.push_back({i == e.size() - 1, e[i]});
  endtask : expect_out
  task automatic run(input int k, input logic [47:0] dst, input int nv,
                     input logic [11:0] v1, input int len, input logic xp);
    logic [31:0] q;
    int          n;
    build(k, dst, nv, v1, len);
    if (xp) expect_out(k, nv);
    else n_drp++;
    if (xp) n_ref++;
    i_peer.send(f);
    n = 0;
    do
    begin
      bus(1'b0, `RFL_OFS_STATE, 32'h0, q);
      n++;
    end
    while ((q[4:0] !== 5'h01 || exq.size() != 0) && n < 300);
    if (n == 300) n_errors++;
    $display("test done: kind %0d length %0d answered %0d", k, len, xp);
  endtask : run
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  // --------
  // watcher and limits
  // --------
  always @(posedge clk)
  begin
    rnd <= ^xs();
    cyc++;
    if (got_v === 1'b1 && exq.size() == 0) n_errors++;
    if (got_v === 1'b1 && exq.size() == 0) $display("wrong value tx byte expected none seen %h", got_b);
    else if (got_v === 1'b1)
    begin
      xb = exq.pop_front();
      `CHK("tx byte", xb, got_b)
    end
    if (cyc == 60000) n_errors++;
    if (cyc == 60000) test_done();
  end
  // --------
  // main sequence
  // --------
  initial
  begin
    logic [31:0] q;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, `RFL_OFS_CTRL, 32'h0, q);
    `CHK("ctrl reset", {20'h0, `RFL_CTRL_RST}, q)
    bus(1'b0, 6'h3C, 32'h0, q);
    `CHK("unmapped read", 32'h0, q)
    bus(1'b1, `RFL_OFS_STAT, 32'hFFFF_FFFF, q);
    bus(1'b0, `RFL_OFS_STAT, 32'h0, q);
    `CHK("stat read only", 32'h0, q)
    bus(1'b1, `RFL_OFS_MACLO, OWN_MAC[31:0], q);
    bus(1'b1, `RFL_OFS_MACHI, {16'h0, OWN_MAC[47:32]}, q);
    bus(1'b1, `RFL_OFS_IP, OWN_IP, q);
    bus(1'b1, `RFL_OFS_VLAN0, 32'h0456_0123, q);
    bus(1'b0, `RFL_OFS_MACHI, 32'h0, q);
    `CHK("own mac high", {16'h0, OWN_MAC[47:32]}, q)
    setc(12'h107);
    run(0, OWN_MAC, 0, 12'h0, 64, 1'b1);
    run(1, OWN_MAC, 0, 12'h0, 90, 1'b1);
    setc(12'h105);
    run(0, PEER_MAC, 0, 12'h0, 70, 1'b1);
    setc(12'h103);
    run(1, OWN_MAC, 0, 12'h0, 64, 1'b1);
    run(0, 48'hFFFF_FFFF_FFFF, 0, 12'h0, 64, 1'b0);
    run(0, 48'h0100_5E00_0001, 0, 12'h0, 64, 1'b0);
    run(0, OWN_MAC, 0, 12'h0, 63, 1'b0);
    full_dup <= 1'b0;
    run(0, OWN_MAC, 0, 12'h0, 64, 1'b0);
    full_dup <= 1'b1;
    setc(12'h11F);
    run(2, 48'hFFFF_FFFF_FFFF, 0, 12'h0, 64, 1'b1);
    run(3, OWN_MAC, 0, 12'h0, 80, 1'b1);
    setc(12'h107);
    run(2, 48'hFFFF_FFFF_FFFF, 0, 12'h0, 64, 1'b0);
    setc(12'h227);
    run(0, OWN_MAC, 2, 12'h456, 72, 1'b1);
    run(0, OWN_MAC, 2, 12'h457, 72, 1'b0);
    run(0, OWN_MAC, 1, 12'h0, 72, 1'b0);
    setc(12'h107);
    slow <= 1'b1;
    for (int i = 0; i < 4; i++) run(i % 2, OWN_MAC, 0, 12'h0, 64 + xs() % 100, 1'b1);
    slow <= 1'b0;
    bus(1'b0, `RFL_OFS_STAT, 32'h0, q);
    `CHK("dropped count", 16'(n_drp), q[31:16])
    `CHK("reflected count", 16'(n_ref), q[15:0])
    setc(12'h106);
    run(0, OWN_MAC, 0, 12'h0, 64, 1'b0);
    test_done();
  end
endmodule : rfl_reflector_tb
`default_nettype wire
